// >>> src/cld_decoder.sv
`timescale 1ns/10ps
// ==========================================
// Word FIFO between bus pairing and executor
module cld_fifo
   import cld_pkg::*;
#(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
)(
   input wire logic clk, // Clock
   input wire logic rst_n, // Synced reset
   input wire logic [WIDTH-1:0] in_data, // Write word
   input wire logic in_valid, // Write request
   output logic in_ready, // Not full
   output logic [WIDTH-1:0] out_data, // Head word
   output logic out_valid, // Not empty
   input wire logic out_ready // Pop
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg, rd_reg;
   logic [AW:0] cnt_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = cnt_reg != (AW+1)'(DEPTH);
   assign out_valid = cnt_reg != '0;
   assign out_data = mem[rd_reg];
   // Storage, no reset needed
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_reg] <= in_data;
   end
   // Pointers wrap at DEPTH
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         if (push)
            wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
         if (pop)
            rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : cld_fifo

// ==========================================
// Instruction interpreter top
module cld_decoder
   import cld_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
)(
   input wire logic clk, // 100 MHz clock
   input wire logic nrst, // Async reset, low
   input wire logic cmd_data_select, // Pin: high = data
   input wire logic rd_wr, // Pin: high = read
   input wire logic enable, // Pin: strobe
   input wire logic [7:0] bus_in, // Pin input level
   output logic [7:0] bus_out, // Pin drive value
   output logic bus_oe, // Pin drive enable
   output logic host_ready, // Low when FIFO full
   output logic busy_flag, // Internal work pending
   output logic bus_8bit, // Bus width setting
   output logic two_line, // Line count setting
   output logic tall_font, // Font height setting
   input wire logic [7:0] disp_code, // Display char code
   input wire logic [2:0] disp_row, // Display glyph row
   output logic [4:0] glyph_pixels, // Row pixels
   input wire logic [6:0] disp_addr, // Display pointer
   output logic [7:0] disp_char // Char RAM code
);
   // ==========================================
   // Functions
   function automatic logic [6:0] step_ptr(logic [6:0] p, logic up, logic gl, logic tl);
      logic [6:0] r;
      r = up ? p + 7'h01 : p - 7'h01;
      if (gl)
         r = {1'b0, r[5:0]};
      else if (!tl)
         r = (up && p == L1_LAST) ? PTR_ZERO : (!up && p == PTR_ZERO) ? L1_LAST : r;
      else if (up)
         r = (p == L2A_LAST) ? L2B_FIRST : (p == L2B_LAST) ? PTR_ZERO : r;
      else
         r = (p == L2B_FIRST) ? L2A_LAST : (p == PTR_ZERO) ? L2B_LAST : r;
      return r;
   endfunction : step_ptr

   // Gaps between and past the two lines map outside storage, so they read 0
   function automatic logic [6:0] char_idx(logic [6:0] p, logic tl);
      return !tl ? p : p[6] ? ((p <= L2B_LAST) ? p - L2B_FIRST + L2_SPAN : 7'(CHAR_DEPTH)) :
         ((p <= L2A_LAST) ? p : 7'(CHAR_DEPTH));
   endfunction : char_idx

   // ==========================================
   // Reset release and pin synchronisers
   logic rst_a_reg, rst_n;
   logic [10:0] pin_a_reg, pin_b_reg;
   logic e_d_reg;
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         {rst_n, rst_a_reg} <= 2'h0;
      else
         {rst_n, rst_a_reg} <= {rst_a_reg, 1'b1};
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_a_reg <= '0;
         pin_b_reg <= '0;
         e_d_reg <= 1'b0;
      end
      else
      begin
         pin_a_reg <= {cmd_data_select, rd_wr, enable, bus_in};
         pin_b_reg <= pin_a_reg;
         e_d_reg <= pin_b_reg[8];
      end
   end
   wire rs_s = pin_b_reg[10];
   wire rw_s = pin_b_reg[9];
   wire e_s = pin_b_reg[8];
   wire [7:0] d_s = pin_b_reg[7:0];
   wire e_fall = e_d_reg && !e_s;

   // ==========================================
   // Nibble pairing into host words
   logic phase_reg;
   logic [3:0] hi_reg;
   cld_word_t push_word, head;
   logic push_valid, head_valid, pop;
   wire last_half = bus_8bit || phase_reg;
   assign push_word = '{cmd_data_select: rs_s, is_read: rw_s,
      data: bus_8bit ? d_s : {hi_reg, d_s[7:4]}};
   // Status reads never queue, so polling cannot block
   assign push_valid = e_fall && last_half && (!rw_s || rs_s);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase_reg <= 1'b0;
         hi_reg <= NIB_ZERO;
      end
      else if (e_fall)
      begin
         phase_reg <= !last_half;
         if (!phase_reg)
            hi_reg <= d_s[7:4];
      end
   end

   cld_fifo #(.WIDTH($bits(cld_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_data(push_word),
      .in_valid(push_valid),
      .in_ready(host_ready),
      .out_data(head),
      .out_valid(head_valid),
      .out_ready(pop)
   );

   // ==========================================
   // Executor state
   cld_exec_t st_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [6:0] ptr_reg;
   logic glyph_sel_reg, inc_reg, lock_reg, pf_load_reg;
   logic [1:0] fs_cnt_reg;
   logic [7:0] prefetch_reg;
   logic [7:0] char_mem [CHAR_DEPTH];
   logic [7:0] glyph_mem [GLYPH_DEPTH];

   assign pop = (st_reg == EX_IDLE) && head_valid;
   assign busy_flag = (st_reg == EX_BUSY) || head_valid;
   wire [7:0] hd = head.data;
   wire is_cmd = pop && !head.cmd_data_select && !head.is_read;
   wire is_wdat = pop && head.cmd_data_select && !head.is_read;
   wire is_rdat = pop && head.cmd_data_select && head.is_read;
   wire op_char = is_cmd && hd[7];
   wire op_glyph = is_cmd && hd[7:6] == OP_GLYPH;
   wire op_fs = is_cmd && hd[7:5] == OP_FS;
   wire op_shift = is_cmd && hd[7:4] == OP_SHIFT && !hd[SH_SC];
   wire op_entry = is_cmd && hd[7:2] == OP_ENTRY;
   // Settings fix on the first set that keeps the width once three earlier sets have passed
   wire fs_final = op_fs && fs_cnt_reg == FS_LOCK_CNT && hd[FS_DL] == bus_8bit;
   wire [6:0] ptr_step = step_ptr(ptr_reg, inc_reg, glyph_sel_reg, two_line);
   wire [6:0] shift_step = step_ptr(ptr_reg, hd[SH_RL], glyph_sel_reg, two_line);
   wire [6:0] cidx = char_idx(ptr_reg, two_line);
   wire c_ok = cidx < 7'(CHAR_DEPTH);
   wire [7:0] ram_rd = glyph_sel_reg ? glyph_mem[ptr_reg[5:0]] : (c_ok ? char_mem[cidx] : 8'h00);

   // Busy timer, one execution time per queued word
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= EX_IDLE;
         cnt_reg <= '0;
      end
      else
         case (st_reg)
            EX_IDLE:
            begin
               if (pop)
               begin
                  st_reg <= EX_BUSY;
                  cnt_reg <= CNT_W'(EXEC_CYC - 1);
               end
            end
            EX_BUSY:
            begin
               cnt_reg <= cnt_reg - 1'b1;
               if (cnt_reg == '0)
                  st_reg <= EX_IDLE;
            end
            default: st_reg <= EX_IDLE;
         endcase
   end

   // Pointer, RAM select and settings
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ptr_reg <= PTR_ZERO;
         glyph_sel_reg <= 1'b0;
         inc_reg <= 1'b1;
         bus_8bit <= 1'b1;
         two_line <= 1'b0;
         tall_font <= 1'b0;
         lock_reg <= 1'b0;
         fs_cnt_reg <= 2'h0;
         pf_load_reg <= 1'b0;
      end
      else
      begin
         pf_load_reg <= op_char || op_glyph || is_rdat || (op_shift && !glyph_sel_reg);
         if (op_char)
         begin
            ptr_reg <= hd[6:0];
            glyph_sel_reg <= 1'b0;
         end
         else if (op_glyph)
         begin
            ptr_reg <= {1'b0, hd[5:0]};
            glyph_sel_reg <= 1'b1;
         end
         else if (is_wdat || is_rdat)
            ptr_reg <= ptr_step;
         else if (op_shift)
            ptr_reg <= shift_step;
         if (op_entry)
            inc_reg <= hd[EM_INC];
         if (op_fs)
         begin
            bus_8bit <= hd[FS_DL];
            if (fs_cnt_reg != FS_LOCK_CNT)
               fs_cnt_reg <= fs_cnt_reg + 2'h1;
         end
         if (op_fs && !lock_reg)
         begin
            two_line <= hd[FS_N];
            tall_font <= hd[FS_F];
         end
         if (fs_final)
            lock_reg <= 1'b1;
      end
   end

   // RAM writes; prefetch only refreshes on loads, not writes
   always_ff @(posedge clk)
   begin
      if (is_wdat && glyph_sel_reg)
         glyph_mem[ptr_reg[5:0]] <= hd;
      if (is_wdat && !glyph_sel_reg && c_ok)
         char_mem[cidx] <= hd;
      disp_char <= (char_idx(disp_addr, two_line) < 7'(CHAR_DEPTH)) ?
         char_mem[char_idx(disp_addr, two_line)] : 8'h00;
      glyph_pixels <= glyph_mem[{disp_code[2:0], disp_row}][4:0];
   end

   // Read register and bus drive
   wire [7:0] rd_byte = rs_s ? prefetch_reg : {busy_flag, ptr_reg};
   wire [7:0] rd_lane = bus_8bit ? rd_byte : phase_reg ? {rd_byte[3:0], NIB_ZERO} : {rd_byte[7:4], NIB_ZERO};
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prefetch_reg <= 8'h00;
         bus_out <= 8'h00;
         bus_oe <= 1'b0;
      end
      else
      begin
         if (pf_load_reg)
            prefetch_reg <= ram_rd;
         bus_out <= rd_lane;
         bus_oe <= e_s && rw_s;
      end
   end

   // ==========================================
   // Checks
   sequence s_high_nibble;
      e_fall && !bus_8bit && !phase_reg;
   endsequence
   a_pair_two_halves: assert property (@(posedge clk) disable iff (!rst_n)
      s_high_nibble |=> phase_reg && !push_valid)
      else $error("high nibble pushed alone");
   a_width_set: assert property (@(posedge clk) disable iff (!rst_n)
      op_fs |=> bus_8bit == $past(hd[FS_DL]))
      else $error("bus width not taken");
   a_lines_set: assert property (@(posedge clk) disable iff (!rst_n)
      op_fs && !lock_reg |=> two_line == $past(hd[FS_N]))
      else $error("line count not taken");
   a_font_set: assert property (@(posedge clk) disable iff (!rst_n)
      op_fs && !lock_reg |=> tall_font == $past(hd[FS_F]))
      else $error("font not taken");
   a_glyph_addr: assert property (@(posedge clk) disable iff (!rst_n)
      op_glyph |=> glyph_sel_reg && ptr_reg == {1'b0, $past(hd[5:0])})
      else $error("glyph address wrong");
   a_char_addr: assert property (@(posedge clk) disable iff (!rst_n)
      op_char |=> !glyph_sel_reg && ptr_reg == $past(hd[6:0]))
      else $error("char address wrong");
   a_wrap_one_line: assert property (@(posedge clk) disable iff (!rst_n)
      is_wdat && !glyph_sel_reg && !two_line && inc_reg && ptr_reg == L1_LAST |=> ptr_reg == PTR_ZERO)
      else $error("one-line wrap wrong");
   a_busy_hold: assert property (@(posedge clk) disable iff (!rst_n)
      pop |=> busy_flag [*8])
      else $error("busy dropped early");
   a_ptr_step: assert property (@(posedge clk) disable iff (!rst_n)
      is_wdat |=> ptr_reg == $past(ptr_step))
      else $error("pointer did not step");
   a_stale_read: assert property (@(posedge clk) disable iff (!rst_n)
      is_wdat && !pf_load_reg |=> $stable(prefetch_reg))
      else $error("write changed prefetch");
   a_settings_lock: assert property (@(posedge clk) disable iff (!rst_n)
      lock_reg && op_fs |=> $stable(two_line) && $stable(tall_font))
      else $error("settings changed after lock");
endmodule : cld_decoder

// >>> pkg/cld_pkg.sv
// ==========================================
// Shared constants and carriers
package cld_pkg;
   // Execution time of one instruction and its cycle count
   localparam int EXEC_NS = 38000;
   localparam int CLK_MHZ = 100;
   localparam int EXEC_CYC = (EXEC_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 12;
   // Character RAM address map
   localparam logic [6:0] L1_LAST = 7'h4F;
   localparam logic [6:0] L2A_LAST = 7'h27;
   localparam logic [6:0] L2B_FIRST = 7'h40;
   localparam logic [6:0] L2B_LAST = 7'h67;
   localparam logic [6:0] L2_SPAN = 7'h28;
   localparam logic [6:0] PTR_ZERO = 7'h00;
   localparam int CHAR_DEPTH = 80;
   localparam int GLYPH_DEPTH = 64;
   // Instruction field positions and opcode prefixes
   localparam int FS_DL = 4;
   localparam int FS_N = 3;
   localparam int FS_F = 2;
   localparam int EM_INC = 1;
   localparam int SH_SC = 3;
   localparam int SH_RL = 2;
   localparam logic [1:0] OP_GLYPH = 2'h1;
   localparam logic [2:0] OP_FS = 3'h1;
   localparam logic [3:0] OP_SHIFT = 4'h1;
   localparam logic [5:0] OP_ENTRY = 6'h01;
   localparam logic [1:0] FS_LOCK_CNT = 2'h3;
   localparam logic [3:0] NIB_ZERO = 4'h0;
   // One host transfer after nibble pairing
   typedef struct packed {
      logic cmd_data_select;
      logic is_read;
      logic [7:0] data;
   } cld_word_t;
   typedef enum logic {EX_IDLE, EX_BUSY} cld_exec_t;
endpackage : cld_pkg

// >>> tb/cld_host_model.sv
`timescale 1ns/10ps
// ==========================================
// Host side of the parallel bus
module cld_host_model
   import cld_pkg::*;
(
   input wire logic clk, // Clock
   output logic cmd_data_select, // Low = instruction
   output logic rd_wr, // High = read
   output logic enable, // Strobe
   output logic [7:0] bus_in, // Lines toward device
   input wire logic [7:0] bus_out, // Device drive value
   input wire logic bus_oe // Device drives lines
);
   logic wide = 1'b1; // Host view of bus width
   initial
   begin
      cmd_data_select = 1'b0;
      rd_wr = 1'b0;
      enable = 1'b0;
      bus_in = 8'h00;
   end
   // One strobe; pins held 5 cycles before and 4 cycles after the falling edge
   task automatic strobe(input logic rs, input logic rd, input logic [7:0] v, output logic [7:0] q);
      @(negedge clk);
      cmd_data_select = rs;
      rd_wr = rd;
      bus_in = rd ? ~bus_in : v;
      enable = 1'b1;
      repeat (5) @(negedge clk);
      q = bus_oe ? bus_out : 8'hXX;
      enable = 1'b0;
      repeat (4) @(negedge clk);
      bus_in = ~bus_in; // Released lines must not keep old value
   endtask : strobe
   // Whole byte; two strobes in 4-bit mode, upper nibble first
   task automatic xfer(input logic rs, input logic rd, input logic [7:0] d, output logic [7:0] q);
      logic [7:0] h;
      strobe(rs, rd, d, h);
      q = h;
      if (!wide)
      begin
         strobe(rs, rd, {d[3:0], d[7:4]}, h);
         q = {q[7:4], h[7:4]};
      end
   endtask : xfer
endmodule : cld_host_model

// >>> tb/tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
   $display("CHECK FAILED at %0t: got %h want %h", $time, a, e); end end
// ==========================================
// Bench top
module tb;
   import cld_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic cds, rdw, en, oe, host_ready, busy, b8, two, tall;
   logic [7:0] bin, bout, dchar, q, v, g, ma, me;
   logic [7:0] code = 8'h00;
   logic [2:0] row = 3'h0;
   logic [4:0] pix;
   logic [6:0] daddr = 7'h00;
   logic [7:0] mem [0:9];
   logic [7:0] exp_q [$];
   logic [7:0] act_q [$];
   int miscompares = 0;
   int num_checks = 0;
   initial
   begin
      forever #5 clk = ~clk;
   end
   cld_decoder #(.FIFO_DEPTH(8)) i_dut (.clk(clk), .nrst(nrst), .cmd_data_select(cds), .rd_wr(rdw),
      .enable(en), .bus_in(bin), .bus_out(bout), .bus_oe(oe), .host_ready(host_ready), .busy_flag(busy),
      .bus_8bit(b8), .two_line(two), .tall_font(tall), .disp_code(code), .disp_row(row),
      .glyph_pixels(pix), .disp_addr(daddr), .disp_char(dchar));
   cld_host_model i_host (.clk(clk), .cmd_data_select(cds), .rd_wr(rdw), .enable(en), .bus_in(bin),
      .bus_out(bout), .bus_oe(oe));
   // ==========================================
   // Helpers
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop
   task automatic note(input logic [7:0] a, input logic [7:0] e);
      act_q.push_back(a);
      exp_q.push_back(e);
   endtask : note
   // Bounded poll of busy; a hang counts as a mismatch
   task automatic idle(input int lim);
      int n;
      n = 0;
      while (busy !== 1'b0)
      begin
         @(negedge clk);
         n++;
         if (n > lim)
         begin
            miscompares++;
            report_and_stop();
         end
      end
   endtask : idle
   task automatic cmd(input logic rs, input logic [7:0] d);
      i_host.xfer(rs, 1'b0, d, q);
      idle(EXEC_CYC + 20);
   endtask : cmd
   task automatic rd(input logic rs, output logic [7:0] r);
      i_host.xfer(rs, 1'b1, 8'h00, r);
      idle(EXEC_CYC + 20);
   endtask : rd
   // Monitor: oldest note against oldest result
   always @(negedge clk)
   begin
      while (act_q.size() > 0)
      begin
         ma = act_q.pop_front();
         me = exp_q.pop_front();
         `CHK(ma, me)
      end
   end
   // ==========================================
   // Main sequence
   initial
   begin
      void'($urandom(80));
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      note({5'h00, b8, two, tall}, 8'h04);
      for (int i = 0; i < 3; i++)
         i_host.xfer(1'b0, 1'b0, 8'h30, q);
      idle(4 * EXEC_CYC);
      cmd(1'b0, 8'h3C);
      note({5'h00, b8, two, tall}, 8'h07);
      cmd(1'b0, 8'h30);
      note({5'h00, b8, two, tall}, 8'h07);
      cmd(1'b0, 8'h06);
      cmd(1'b0, 8'h80);
      // Back-to-back data writes until the queue refuses
      for (int i = 0; i < 10; i++)
      begin
         mem[i] = 8'($urandom);
         i_host.xfer(1'b1, 1'b0, mem[i], q);
         if (i == 8)
            note({7'h00, host_ready}, 8'h00);
      end
      // Status read while the queue drains must show busy
      i_host.xfer(1'b0, 1'b1, 8'h00, v);
      note({7'h00, v[7]}, 8'h01);
      idle(10 * EXEC_CYC);
      rd(1'b0, v);
      note(v, 8'h09);
      for (int i = 0; i < 9; i++)
      begin
         daddr = 7'(i);
         repeat (2) @(negedge clk);
         note(dchar, mem[i]);
      end
      daddr = 7'h28;
      repeat (2) @(negedge clk);
      note(dchar, 8'h00);
      // Switch to 4-bit; one strobe while still 8-bit wide
      cmd(1'b0, 8'h20);
      i_host.wide = 1'b0;
      note({5'h00, b8, two, tall}, 8'h03);
      cmd(1'b0, 8'h48);
      g = 8'($urandom);
      cmd(1'b1, g);
      code = 8'h09;
      repeat (2) @(negedge clk);
      note({3'h0, pix}, {3'h0, g[4:0]});
      rd(1'b0, v);
      note(v, 8'h09);
      cmd(1'b0, 8'h83);
      rd(1'b1, v);
      note(v, mem[3]);
      rd(1'b0, v);
      note(v, 8'h04);
      // Cursor shift left reloads the read register from position 3
      cmd(1'b0, 8'h10);
      rd(1'b0, v);
      note(v, 8'h03);
      cmd(1'b0, 8'h04);
      cmd(1'b1, 8'h5A);
      rd(1'b0, v);
      note(v, 8'h02);
      rd(1'b1, v);
      note(v, mem[3]);
      repeat (4) @(negedge clk);
      report_and_stop();
   end
endmodule : tb
